// ### pkg/stc_pkg.sv
// Purpose: Constants and types for the sine test tone configuration block
// Assumes: 13-bit serial port addresses, 8-bit register data
// Notes:   Field positions follow the register layout
package stc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] SINE_TONE_AMPLITUDE_ADDR  = 13'h118;
  localparam logic [12:0] SINE_TONE_DC_OFFSET_ADDR  = 13'h119;
  localparam logic [12:0] TEST_CHANNEL_ENABLES_ADDR = 13'h11A;

  localparam logic [3:0] AMP_RESET  = 4'h0;
  localparam logic [4:0] MULT_RESET = 5'h00;
  localparam logic [2:0] EXP_RESET  = 3'h0;
  localparam logic [7:0] EN_RESET   = 8'h00;

  // Field positions
  localparam int unsigned AMP_LSB  = 0;
  localparam int unsigned EXP_LSB  = 0;
  localparam int unsigned MULT_LSB = 3;

  // Offset scale: full scale times multiplier times 2^-(13 - exponent)
  localparam int unsigned OFS_FRAC_BITS = 13;

  // Serial frame: read flag, two length bits, address, then one data byte
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned RW_BIT     = 15;

  localparam int unsigned NUM_CH = 8;

  typedef struct packed {
    logic [3:0]        amp;
    logic signed [4:0] mult;
    logic [2:0]        expo;
    logic [7:0]        ch_en;
  } stc_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA  = 4'h4,
    ST_DONE  = 4'h8
  } stc_state_t;

endpackage

// ### src/stc_top.sv
// Purpose: Sine test tone settings, serial configuration port, channel mux
// Assumes: Serial clock at most one eighth of the system clock
// Notes:   Test samples are scaled, offset and saturated; one cycle latency
//
// Overview of operation
// - Tone amplitude is full scale divided by two to the amplitude code.
// - Offset multiplier is a 5-bit two's complement value, +15 down to -16.
// - Offset exponent is a 3-bit unsigned value, default zero.
// - Offset equals full scale times multiplier times 2^-(13-exponent).
// - Eight channel enable bits, bit 0 first channel, one selects test.
`timescale 1ns/1ps
module stc_top #(
  parameter int unsigned DW = 16
) (
  input  wire logic                            clock,
  input  wire logic                            rst,
  input  wire logic                            spi_clk_pin,
  input  wire logic                            spi_cs_n_pin,
  input  wire logic                            spi_dio_in,
  output logic                                 spi_dio_out,
  output logic                                 spi_dio_oe,
  input  wire logic signed [DW-1:0]            tone_in,
  input  wire logic [stc_pkg::NUM_CH-1:0][DW-1:0] adc_in,
  output logic [stc_pkg::NUM_CH-1:0][DW-1:0]   ch_out,
  output stc_pkg::stc_cfg_t                    cfg_out
);
  import stc_pkg::*;

  localparam int OFS_BASE = int'(DW) - 1 - int'(OFS_FRAC_BITS);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sck_sync_reg, sck_sync_next;
  logic [2:0] cs_sync_reg,  cs_sync_next;
  logic [2:0] dio_sync_reg, dio_sync_next;
  logic       sck_lvl_reg,  sck_lvl_next;
  logic       cs_lvl_reg,   cs_lvl_next;
  logic       sck_rise, sck_fall;

  always_comb begin
    sck_sync_next = {sck_sync_reg[1:0], spi_clk_pin};
    cs_sync_next  = {cs_sync_reg[1:0], spi_cs_n_pin};
    dio_sync_next = {dio_sync_reg[1:0], spi_dio_in};
    sck_lvl_next  = sck_lvl_reg;
    cs_lvl_next   = cs_lvl_reg;
    if (sck_sync_reg[1] == sck_sync_reg[2]) begin
      sck_lvl_next = sck_sync_reg[2];
    end
    if (cs_sync_reg[1] == cs_sync_reg[2]) begin
      cs_lvl_next = cs_sync_reg[2];
    end
    sck_rise = sck_lvl_next & ~sck_lvl_reg;
    sck_fall = ~sck_lvl_next & sck_lvl_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg  <= 3'h7;
      dio_sync_reg <= 3'h0;
      sck_lvl_reg  <= 1'b0;
      cs_lvl_reg   <= 1'b1;
    end else begin
      sck_sync_reg <= sck_sync_next;
      cs_sync_reg  <= cs_sync_next;
      dio_sync_reg <= dio_sync_next;
      sck_lvl_reg  <= sck_lvl_next;
      cs_lvl_reg   <= cs_lvl_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial port and registers
  // ----------------------------------------------------------------
  stc_state_t        st_reg,   st_next;
  logic [15:0]       sh_reg,   sh_next;
  logic [7:0]        rd_reg,   rd_next;
  logic [4:0]        cnt_reg,  cnt_next;
  logic              rw_reg,   rw_next;
  logic [12:0]       addr_reg, addr_next;
  logic              dout_reg, dout_next;
  logic              oe_reg,   oe_next;
  logic [3:0]        amp_reg,  amp_next;
  logic signed [4:0] mult_reg, mult_next;
  logic [2:0]        exp_reg,  exp_next;
  logic [7:0]        en_reg,   en_next;
  logic [15:0]       instr_w;
  logic [7:0]        rdata;
  logic [7:0]        wdata;

  always_comb begin
    st_next   = st_reg;
    sh_next   = sh_reg;
    rd_next   = rd_reg;
    cnt_next  = cnt_reg;
    rw_next   = rw_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    oe_next   = oe_reg;
    amp_next  = amp_reg;
    mult_next = mult_reg;
    exp_next  = exp_reg;
    en_next   = en_reg;
    instr_w   = {sh_reg[14:0], dio_sync_reg[2]};
    wdata     = instr_w[7:0];
    rdata     = 8'h00;
    case (instr_w[12:0])
      SINE_TONE_AMPLITUDE_ADDR:  rdata = {4'h0, amp_reg};
      SINE_TONE_DC_OFFSET_ADDR:  rdata = {mult_reg, exp_reg};
      TEST_CHANNEL_ENABLES_ADDR: rdata = en_reg;
      default:                   rdata = 8'h00;
    endcase
    case (st_reg)
      ST_IDLE: begin
        cnt_next = 5'h00;
        oe_next  = 1'b0;
        if (!cs_lvl_reg) begin
          st_next = ST_INSTR;
        end
      end
      ST_INSTR: begin
        if (sck_rise) begin
          sh_next  = instr_w;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(INSTR_BITS - 1)) begin
            rw_next   = instr_w[RW_BIT];
            addr_next = instr_w[12:0];
            rd_next   = rdata;
            cnt_next  = 5'h00;
            st_next   = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (sck_fall && rw_reg) begin
          dout_next = rd_reg[7];
          oe_next   = 1'b1;
          rd_next   = {rd_reg[6:0], 1'b0};
        end
        if (sck_rise) begin
          sh_next  = instr_w;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'(DATA_BITS - 1)) begin
            st_next = ST_DONE;
            if (!rw_reg) begin
              case (addr_reg)
                SINE_TONE_AMPLITUDE_ADDR: begin
                  amp_next = wdata[AMP_LSB +: 4];
                end
                SINE_TONE_DC_OFFSET_ADDR: begin
                  mult_next = signed'(wdata[MULT_LSB +: 5]);
                  exp_next  = wdata[EXP_LSB +: 3];
                end
                TEST_CHANNEL_ENABLES_ADDR: begin
                  en_next = wdata;
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
      ST_DONE: begin
      end
      default: st_next = ST_IDLE;
    endcase
    if (cs_lvl_reg) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg   <= ST_IDLE;
      sh_reg   <= 16'h0000;
      rd_reg   <= 8'h00;
      cnt_reg  <= 5'h00;
      rw_reg   <= 1'b0;
      addr_reg <= 13'h0000;
      dout_reg <= 1'b0;
      oe_reg   <= 1'b0;
      amp_reg  <= AMP_RESET;
      mult_reg <= MULT_RESET;
      exp_reg  <= EXP_RESET;
      en_reg   <= EN_RESET;
    end else begin
      st_reg   <= st_next;
      sh_reg   <= sh_next;
      rd_reg   <= rd_next;
      cnt_reg  <= cnt_next;
      rw_reg   <= rw_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      oe_reg   <= oe_next;
      amp_reg  <= amp_next;
      mult_reg <= mult_next;
      exp_reg  <= exp_next;
      en_reg   <= en_next;
    end
  end

  assign spi_dio_out = dout_reg;
  assign spi_dio_oe  = oe_reg;
  assign cfg_out     = '{amp: amp_reg, mult: mult_reg, expo: exp_reg,
                         ch_en: en_reg};

  // ----------------------------------------------------------------
  // Test sample and channel select
  // ----------------------------------------------------------------
  logic signed [DW:0]          tone_scaled;
  logic signed [DW:0]          ofs_val;
  logic signed [DW:0]          sum_val;
  logic [DW-1:0]               test_val;
  logic [NUM_CH-1:0][DW-1:0]   ch_next;
  logic [NUM_CH-1:0][DW-1:0]   ch_reg;

  always_comb begin
    tone_scaled = (DW+1)'(tone_in) >>> amp_reg;
    ofs_val     = (DW+1)'(mult_reg) <<< (int'(exp_reg) + OFS_BASE);
    sum_val     = tone_scaled + ofs_val;
    if (sum_val[DW] != sum_val[DW-1]) begin
      test_val = {sum_val[DW], {(DW-1){~sum_val[DW]}}};
    end else begin
      test_val = sum_val[DW-1:0];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      ch_next[i] = en_reg[i] ? test_val : adc_in[i];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ch_reg <= '0;
    end else begin
      ch_reg <= ch_next;
    end
  end

  assign ch_out = ch_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  full_scale_a: assert property (
    (en_reg[0] && amp_reg == 4'h0 && mult_reg == 5'sh00)
    |=> ch_out[0] == $past(tone_in))
    else $error("amplitude code zero does not pass full scale");

  amp_divide_a: assert property (
    (en_reg[1] && amp_reg == 4'h1 && mult_reg == 5'sh00
     && tone_in == DW'(16'h4000))
    |=> ch_out[1] == DW'(16'h2000))
    else $error("amplitude code one does not halve the tone");

  neg_mult_a: assert property (
    (en_reg[2] && mult_reg == 5'sh1F && exp_reg == 3'h0 && tone_in == '0)
    |=> $signed(ch_out[2]) == -(1 <<< OFS_BASE))
    else $error("multiplier all ones is not minus one");

  exp_step_a: assert property (
    (en_reg[3] && mult_reg == 5'sh01 && exp_reg == 3'h7 && tone_in == '0)
    |=> ch_out[3] == DW'(1 << (7 + OFS_BASE)))
    else $error("exponent code seven gives wrong offset");

  offset_sum_a: assert property (
    (en_reg[4] && amp_reg == 4'h0 && mult_reg == 5'sh0F
     && exp_reg == 3'h0 && tone_in == DW'(16'h0100))
    |=> ch_out[4] == DW'(16'h0100 + (15 << OFS_BASE)))
    else $error("offset not added to test tone");

  route_test_a: assert property (
    en_reg[7] |=> ch_out[7] == $past(test_val))
    else $error("enabled channel does not carry test signal");

  enable_reset_a: assert property (
    $rose(!rst) |-> en_reg == EN_RESET && amp_reg == AMP_RESET)
    else $error("settings not at default after reset");

  pass_through_a: assert property (
    !en_reg[5] |=> ch_out[5] == $past(adc_in[5]))
    else $error("disabled channel lost its normal data");

endmodule

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the sine test tone configuration block
// Assumes: Serial frames of 24 bits, serial clock phases of 8 system clocks
// Notes:   Random values come from an LFSR with a fixed start value
`timescale 1ns/1ps
module testbench;
  import stc_pkg::*;
  localparam int DW = 16;
  logic                      clock = 1'b0;
  logic                      rst = 1'b1;
  logic                      sclk = 1'b0;
  logic                      cs_n = 1'b1;
  logic                      dio = 1'b0;
  logic                      spi_dio_out;
  logic                      spi_dio_oe;
  logic signed [DW-1:0]      tone_in = '0;
  logic [NUM_CH-1:0][DW-1:0] adc_in = '0;
  logic [NUM_CH-1:0][DW-1:0] ch_out;
  stc_cfg_t                  cfg_out;
  logic [3:0]                amp_s = 4'h0;
  logic [4:0]                mult_s = 5'h00;
  logic [2:0]                expo_s = 3'h0;
  logic [7:0]                en_s = 8'h00;
  logic [31:0]               seed = 32'h6BA66260;
  int                        bad_count = 0;
  int                        n_compared = 0;

  stc_top #(.DW(DW)) dut_u (
    .clock(clock), .rst(rst), .spi_clk_pin(sclk), .spi_cs_n_pin(cs_n),
    .spi_dio_in(dio), .spi_dio_out(spi_dio_out), .spi_dio_oe(spi_dio_oe),
    .tone_in(tone_in), .adc_in(adc_in), .ch_out(ch_out), .cfg_out(cfg_out)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [DW-1:0] exp_ch(logic signed [DW-1:0] t);
    int s;
    s = (int'(t) >>> amp_s)
        + int'($signed(mult_s)) * (1 << (expo_s + DW - 14));
    if (s > (1 << (DW - 1)) - 1)
      s = (1 << (DW - 1)) - 1;
    if (s < -(1 << (DW - 1)))
      s = -(1 << (DW - 1));
    return s[DW-1:0];
  endfunction

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Serial port frames
  // ----------------------------------------------------------------
  task automatic frame(logic rd, logic [12:0] a, logic [7:0] wd,
                       output logic [7:0] rdat);
    logic [23:0] w;
    w = {rd, 2'b00, a, wd};
    rdat = 8'h00;
    cs_n = 1'b0;
    tick(8);
    for (int i = 23; i >= 0; i--) begin
      dio = w[i];
      tick(8);
      if (i < 8) begin
        rdat[i] = spi_dio_out;
        check("dio_oe", spi_dio_oe, rd);
      end
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
    end
    tick(8);
    cs_n = 1'b1;
    dio = ~dio;
    tick(8);
    check("dio_oe", spi_dio_oe, 1'b0);
  endtask

  task automatic wr(logic [12:0] a, logic [7:0] d);
    logic [7:0] x;
    frame(1'b0, a, d, x);
  endtask

  // ----------------------------------------------------------------
  // Checks of registers and datapath
  // ----------------------------------------------------------------
  task automatic chk();
    logic [7:0] r;
    logic [DW-1:0] e;
    frame(1'b1, SINE_TONE_AMPLITUDE_ADDR, 8'h00, r);
    check("amp_reg", r, {4'h0, amp_s});
    frame(1'b1, SINE_TONE_DC_OFFSET_ADDR, 8'h00, r);
    check("ofs_reg", r, {mult_s, expo_s});
    frame(1'b1, TEST_CHANNEL_ENABLES_ADDR, 8'h00, r);
    check("en_reg", r, en_s);
    check("cfg_out", cfg_out,
          {amp_s, mult_s, expo_s, en_s});
    for (int k = 0; k < 7; k++) begin
      seed = lfsr(seed);
      case (k)
        0: tone_in = 16'h7FFF;
        1: tone_in = 16'h8000;
        2: tone_in = 16'h0000;
        3: tone_in = 16'h4000;
        4: tone_in = 16'h0100;
        default: tone_in = seed[DW-1:0];
      endcase
      for (int c = 0; c < NUM_CH; c++) begin
        seed = lfsr(seed);
        adc_in[c] = seed[31:16];
      end
      tick(1);
      for (int c = 0; c < NUM_CH; c++) begin
        e = en_s[c] ? exp_ch(tone_in) : adc_in[c];
        check("ch_out", ch_out[c], e);
      end
    end
  endtask

  task automatic set_cfg(logic [3:0] a, logic [4:0] m, logic [2:0] x,
                         logic [7:0] en, logic [3:0] junk);
    wr(SINE_TONE_AMPLITUDE_ADDR, {junk, a});
    wr(SINE_TONE_DC_OFFSET_ADDR, {m, x});
    wr(TEST_CHANNEL_ENABLES_ADDR, en);
    amp_s = a;
    mult_s = m;
    expo_s = x;
    en_s = en;
    chk();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial begin
    tick(20);
    rst = 1'b0;
    tick(4);
    chk();
    set_cfg(4'h0, 5'h0F, 3'h7, 8'h01, 4'hF);
    set_cfg(4'hF, 5'h10, 3'h7, 8'h80, 4'hA);
    set_cfg(4'h1, 5'h1F, 3'h0, 8'hAA, 4'h5);
    set_cfg(4'h2, 5'h00, 3'h1, 8'hFF, 4'h0);
    set_cfg(4'h0, 5'h00, 3'h3, 8'h41, 4'h3);
    set_cfg(4'h1, 5'h00, 3'h5, 8'h22, 4'h6);
    set_cfg(4'h3, 5'h1F, 3'h0, 8'h14, 4'h9);
    set_cfg(4'h6, 5'h01, 3'h7, 8'h88, 4'hC);
    set_cfg(4'h0, 5'h0F, 3'h0, 8'h10, 4'h1);
    wr(13'h11B, 8'hFF);
    chk();
    for (int n = 0; n < 5; n++) begin
      seed = lfsr(seed);
      set_cfg(seed[3:0], seed[8:4], seed[11:9], seed[19:12], seed[23:20]);
    end
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    amp_s = 4'h0;
    mult_s = 5'h00;
    expo_s = 3'h0;
    en_s = 8'h00;
    tick(4);
    chk();
    summarize();
  end
endmodule
